// File: hw/serial_frame_bist_loop_control.sv
// Receive framer, self-test checker, loop-through select and AHB-Lite registers
`timescale 1ns/1ps
module serial_frame_bist_loop_control
    import serial_link_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic link_clk,
    input wire logic link_data,
    input wire logic realign_permit,
    input wire logic rx_selftest_enable_n,
    input wire logic loop_through_select,
    input wire logic rate_range_strap,
    input wire logic cascade_timing_strap,
    input wire logic rx_fifo_nearly_full,
    input wire logic [7:0] tx_fifo_char,
    input wire logic tx_char_req,
    output logic [7:0] tx_enc_char,
    output logic tx_enc_from_loop,
    output logic tx_fifo_pop,
    output logic [7:0] rx_char,
    output logic rx_char_valid,
    output logic rx_violation,
    output logic rx_fifo_full_flag,
    output logic irq
);

    function automatic logic [9:0] rev10(input logic [9:0] v);
        logic [9:0] r;
        r = '0;
        for (int i = 0; i < CHAR_BITS; i++) begin
            r[i] = v[CHAR_BITS-1-i];
        end
        return r;
    endfunction

    function automatic logic is_comma(input logic [9:0] w);
        return (w == COMMA_NEG) || (w == COMMA_POS);
    endfunction

    function automatic logic [8:0] lfsr_step(input logic [8:0] s);
        return {s[7:0], s[LFSR_TAP_A] ^ s[LFSR_TAP_B]};
    endfunction

    // Pin synchronisers; the last stage of link_clk is kept for edge finding
    logic [1:0] lclk_sync_reg;
    logic lclk_prev_reg;
    logic [1:0] ldat_sync_reg;
    logic [1:0] permit_sync_reg;
    logic [1:0] bist_n_sync_reg;
    logic [1:0] loop_sync_reg;
    logic [1:0] rate_sync_reg;
    logic [1:0] casc_sync_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lclk_sync_reg <= 2'h0;
            lclk_prev_reg <= 1'h0;
            ldat_sync_reg <= 2'h0;
            permit_sync_reg <= 2'h0;
            bist_n_sync_reg <= 2'h3;
            loop_sync_reg <= 2'h0;
            rate_sync_reg <= 2'h0;
            casc_sync_reg <= 2'h0;
        end else if (clk_en) begin
            lclk_sync_reg <= {lclk_sync_reg[0], link_clk};
            lclk_prev_reg <= lclk_sync_reg[1];
            ldat_sync_reg <= {ldat_sync_reg[0], link_data};
            permit_sync_reg <= {permit_sync_reg[0], realign_permit};
            bist_n_sync_reg <= {bist_n_sync_reg[0], rx_selftest_enable_n};
            loop_sync_reg <= {loop_sync_reg[0], loop_through_select};
            rate_sync_reg <= {rate_sync_reg[0], rate_range_strap};
            casc_sync_reg <= {casc_sync_reg[0], cascade_timing_strap};
        end
    end

    wire logic bit_stb = lclk_sync_reg[1] & ~lclk_prev_reg;
    wire logic permit = permit_sync_reg[1];
    wire logic selftest_on = ~bist_n_sync_reg[1];
    wire logic loop_sel = loop_sync_reg[1];
    wire logic cascade = casc_sync_reg[1];

    // Control register
    logic [CTRL_W-1:0] ctrl_reg;
    wire logic link_en = ctrl_reg[CTRL_LINK_EN_BIT];

    // Framer: shift register holds the last ten bits, newest in the msb
    logic [9:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic framed_reg;
    logic [9:0] char_raw_reg;
    logic char_stb_reg;
    logic realign_stb_reg;

    wire logic [9:0] shift_next = {ldat_sync_reg[1], shift_reg[9:1]};
    wire logic [9:0] window = rev10(shift_next);
    wire logic window_comma = is_comma(window);
    wire logic slot_end = (bit_cnt_reg == BIT_CNT_LAST);
    // A comma only moves the boundary when the framer is permitted
    wire logic take_comma = permit & window_comma;
    wire logic char_end = slot_end | take_comma;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_reg <= 10'h000;
            bit_cnt_reg <= 4'h0;
            framed_reg <= 1'h0;
            char_raw_reg <= 10'h000;
            char_stb_reg <= 1'h0;
            realign_stb_reg <= 1'h0;
        end else if (clk_en) begin
            char_stb_reg <= 1'h0;
            realign_stb_reg <= 1'h0;
            if (bit_stb && link_en) begin
                shift_reg <= shift_next;
                if (char_end) begin
                    bit_cnt_reg <= 4'h0;
                    char_raw_reg <= window;
                    char_stb_reg <= 1'h1;
                end else begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
                if (take_comma) begin
                    framed_reg <= 1'h1;
                    realign_stb_reg <= ~slot_end;
                end
            end
        end
    end

    logic [7:0] dec_data;
    logic dec_k;
    logic dec_err;

    char_decoder u_dec (
        .code_in(char_raw_reg),
        .data_out(dec_data),
        .is_k(dec_k),
        .code_err(dec_err)
    );

    // Self-test sequencer; first character after enable is the sequence's first
    selftest_state_e st_reg;
    selftest_state_e st_next;
    logic [8:0] lfsr_reg;
    logic [8:0] seq_idx_reg;
    logic [COUNT_W-1:0] viol_cnt_reg;
    logic [COUNT_W-1:0] loop_cnt_reg;

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            ST_IDLE: begin
                if (selftest_on) begin
                    st_next = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (!selftest_on) begin
                    st_next = ST_IDLE;
                end else if (char_stb_reg) begin
                    st_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!selftest_on) begin
                    st_next = ST_IDLE;
                end
            end
            default: st_next = ST_IDLE;
        endcase
    end

    wire logic checking = selftest_on && (st_reg != ST_IDLE) && char_stb_reg;
    wire logic mismatch = dec_err || (dec_data != lfsr_reg[7:0]);
    wire logic pass_done = checking && (seq_idx_reg == SEQ_LAST);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= ST_IDLE;
            lfsr_reg <= LFSR_SEED;
            seq_idx_reg <= 9'h000;
            viol_cnt_reg <= '0;
            loop_cnt_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
            if (st_reg == ST_IDLE) begin
                lfsr_reg <= LFSR_SEED;
                seq_idx_reg <= 9'h000;
                if (selftest_on) begin
                    viol_cnt_reg <= '0;
                    loop_cnt_reg <= '0;
                end
            end else if (checking) begin
                lfsr_reg <= lfsr_step(lfsr_reg);
                seq_idx_reg <= pass_done ? 9'h000 : seq_idx_reg + 9'h001;
                if (mismatch && (viol_cnt_reg != '1)) begin
                    viol_cnt_reg <= viol_cnt_reg + 1'b1;
                end
                if (pass_done) begin
                    loop_cnt_reg <= loop_cnt_reg + 1'b1;
                end
            end
        end
    end

    // Received character, violation and full flag outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_char <= 8'h00;
            rx_char_valid <= 1'h0;
            rx_violation <= 1'h0;
            rx_fifo_full_flag <= 1'h1;
        end else if (clk_en) begin
            rx_char_valid <= char_stb_reg;
            if (char_stb_reg) begin
                rx_char <= dec_data;
                rx_violation <= checking & mismatch;
            end else if (!selftest_on) begin
                rx_violation <= 1'h0;
            end
            // Self-test borrows the flag for the pass pulse, polarity per strap
            if (selftest_on) begin
                rx_fifo_full_flag <= cascade ? pass_done : ~pass_done;
            end else begin
                rx_fifo_full_flag <= cascade ? rx_fifo_nearly_full : ~rx_fifo_nearly_full;
            end
        end
    end

    // Transmit encoder source; the elasticity stage is the last received character
    wire logic [7:0] tx_src = loop_sel ? rx_char : tx_fifo_char;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_enc_char <= 8'h00;
            tx_enc_from_loop <= 1'h0;
            tx_fifo_pop <= 1'h0;
        end else if (clk_en) begin
            tx_enc_from_loop <= loop_sel;
            tx_fifo_pop <= tx_char_req & ~loop_sel;
            if (tx_char_req) begin
                tx_enc_char <= tx_src;
            end
        end
    end

    // AHB-Lite slave: zero wait states, read data prepared in the address phase
    wire logic addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
    wire logic [7:0] addr_ofs = {haddr[7:2], 2'h0};
    logic wr_pend_reg;
    logic [7:0] wr_ofs_reg;
    logic [INT_W-1:0] int_stat_reg;
    logic [INT_W-1:0] int_en_reg;

    wire logic wr_data = wr_pend_reg;
    wire logic wr_ctrl = wr_data && (wr_ofs_reg == CTRL_OFS);
    wire logic wr_clr = wr_data && (wr_ofs_reg == INT_CLR_OFS);
    wire logic wr_en = wr_data && (wr_ofs_reg == INT_EN_OFS);

    wire logic [31:0] status_word = 32'({casc_sync_reg[1], rate_sync_reg[1], loop_sel,
        rx_violation, selftest_on, framed_reg});
    wire logic [31:0] count_word = {loop_cnt_reg, viol_cnt_reg};
    wire logic [31:0] char_word = 32'({dec_k, char_raw_reg, rx_char});
    wire logic [31:0] rd_word =
        (addr_ofs == CTRL_OFS) ? 32'(ctrl_reg) :
        (addr_ofs == STATUS_OFS) ? status_word :
        (addr_ofs == COUNT_OFS) ? count_word :
        (addr_ofs == INT_STAT_OFS) ? 32'(int_stat_reg) :
        (addr_ofs == INT_EN_OFS) ? 32'(int_en_reg) :
        (addr_ofs == CHAR_OFS) ? char_word : 32'h0000_0000;

    // Sticky events: a set in the same cycle as a clear wins
    wire logic [INT_W-1:0] int_set = {checking & dec_err, pass_done,
        checking & mismatch, realign_stb_reg};
    wire logic [INT_W-1:0] int_clr = wr_clr ? hwdata[INT_W-1:0] : '0;
    wire logic [INT_W-1:0] int_stat_next = (int_stat_reg & ~int_clr) | int_set;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'h0;
            wr_ofs_reg <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'h1;
            hresp <= HRESP_OKAY;
        end else if (clk_en) begin
            wr_pend_reg <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_ofs_reg <= addr_ofs;
            end
            if (addr_ok && !hwrite) begin
                hrdata <= rd_word;
            end
            hreadyout <= 1'h1;
            hresp <= HRESP_OKAY;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= CTRL_RESET;
            int_en_reg <= INT_EN_RESET;
            int_stat_reg <= '0;
            irq <= 1'h0;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                ctrl_reg <= hwdata[CTRL_W-1:0];
            end
            if (wr_en) begin
                int_en_reg <= hwdata[INT_W-1:0];
            end
            int_stat_reg <= int_stat_next;
            irq <= |(int_stat_next & (wr_en ? hwdata[INT_W-1:0] : int_en_reg));
        end
    end

endmodule

// File: hw/serial_link_pkg.sv
// Shared constants and types for the serial framing, self-test and loop-through block
package serial_link_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] COUNT_OFS = 8'h08;
    localparam logic [7:0] INT_STAT_OFS = 8'h0C;
    localparam logic [7:0] INT_CLR_OFS = 8'h10;
    localparam logic [7:0] INT_EN_OFS = 8'h14;
    localparam logic [7:0] CHAR_OFS = 8'h18;

    // Control register fields
    localparam int CTRL_LINK_EN_BIT = 0;
    localparam int CTRL_W = 1;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 1'h1;

    // Status register fields
    localparam int STAT_FRAMED_BIT = 0;
    localparam int STAT_SELFTEST_BIT = 1;
    localparam int STAT_VIOL_BIT = 2;
    localparam int STAT_LOOP_BIT = 3;
    localparam int STAT_RATE_BIT = 4;
    localparam int STAT_CASCADE_BIT = 5;

    // Interrupt fields, common to status, clear and enable
    localparam int INT_REALIGN_BIT = 0;
    localparam int INT_VIOL_BIT = 1;
    localparam int INT_LOOP_BIT = 2;
    localparam int INT_CODE_ERR_BIT = 3;
    localparam int INT_W = 4;
    localparam logic [INT_W-1:0] INT_EN_RESET = 4'h0;

    // Count register layout
    localparam int COUNT_W = 16;
    localparam int COUNT_LOOP_LSB = 16;

    // Character register layout
    localparam int CHAR_RAW_LSB = 8;
    localparam int CHAR_K_BIT = 18;

    // Line code, written first bit received (a) in the msb
    localparam int CHAR_BITS = 10;
    localparam logic [3:0] BIT_CNT_LAST = 4'h9;
    localparam logic [9:0] COMMA_NEG = 10'h0FA;
    localparam logic [9:0] COMMA_POS = 10'h305;

    // Self-test sequence: 9-bit maximal LFSR, 511 characters per pass
    localparam int SEQ_LEN = 511;
    localparam logic [8:0] SEQ_LAST = 9'h1FE;
    localparam logic [8:0] LFSR_SEED = 9'h1FF;
    localparam int LFSR_TAP_A = 8;
    localparam int LFSR_TAP_B = 4;

    // AHB-Lite
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_RUN = 3'b100
    } selftest_state_e;

endpackage

// File: hw/char_decoder.sv
// Combinational 10-bit to 8-bit line-code character decoder
`timescale 1ns/1ps
module char_decoder
    import serial_link_pkg::*;
(
    input wire logic [9:0] code_in,
    output logic [7:0] data_out,
    output logic is_k,
    output logic code_err
);

    // Six-bit sub-block (abcdei, a in msb) to EDCBA, with a valid flag
    function automatic logic [5:0] dec6(input logic [5:0] c);
        case (c)
            6'b100111, 6'b011000: dec6 = 6'h20;
            6'b011101, 6'b100010: dec6 = 6'h21;
            6'b101101, 6'b010010: dec6 = 6'h22;
            6'b110001: dec6 = 6'h23;
            6'b110101, 6'b001010: dec6 = 6'h24;
            6'b101001: dec6 = 6'h25;
            6'b011001: dec6 = 6'h26;
            6'b111000, 6'b000111: dec6 = 6'h27;
            6'b111001, 6'b000110: dec6 = 6'h28;
            6'b100101: dec6 = 6'h29;
            6'b010101: dec6 = 6'h2A;
            6'b110100: dec6 = 6'h2B;
            6'b001101: dec6 = 6'h2C;
            6'b101100: dec6 = 6'h2D;
            6'b011100: dec6 = 6'h2E;
            6'b010111, 6'b101000: dec6 = 6'h2F;
            6'b011011, 6'b100100: dec6 = 6'h30;
            6'b100011: dec6 = 6'h31;
            6'b010011: dec6 = 6'h32;
            6'b110010: dec6 = 6'h33;
            6'b001011: dec6 = 6'h34;
            6'b101010: dec6 = 6'h35;
            6'b011010: dec6 = 6'h36;
            6'b111010, 6'b000101: dec6 = 6'h37;
            6'b110011, 6'b001100: dec6 = 6'h38;
            6'b100110: dec6 = 6'h39;
            6'b010110: dec6 = 6'h3A;
            6'b110110, 6'b001001: dec6 = 6'h3B;
            6'b001110, 6'b001111, 6'b110000: dec6 = 6'h3C;
            6'b101110, 6'b010001: dec6 = 6'h3D;
            6'b011110, 6'b100001: dec6 = 6'h3E;
            6'b101011, 6'b010100: dec6 = 6'h3F;
            default: dec6 = 6'h00;
        endcase
    endfunction

    // Four-bit sub-block (fghj, f in msb) to HGF, with a valid flag
    function automatic logic [3:0] dec4(input logic [3:0] c);
        case (c)
            4'b1011, 4'b0100: dec4 = 4'h8;
            4'b1001: dec4 = 4'h9;
            4'b0101: dec4 = 4'hA;
            4'b1100, 4'b0011: dec4 = 4'hB;
            4'b1101, 4'b0010: dec4 = 4'hC;
            4'b1010: dec4 = 4'hD;
            4'b0110: dec4 = 4'hE;
            4'b1110, 4'b0001, 4'b0111, 4'b1000: dec4 = 4'hF;
            default: dec4 = 4'h0;
        endcase
    endfunction

    wire logic [5:0] six = code_in[9:4];
    wire logic k28 = (six == 6'b001111) || (six == 6'b110000);
    // After a positive-disparity K28 the four-bit group comes inverted
    wire logic [3:0] four = (six == 6'b110000) ? ~code_in[3:0] : code_in[3:0];
    wire logic [5:0] lo = dec6(six);
    wire logic [3:0] hi = dec4(four);

    assign data_out = {hi[2:0], lo[4:0]};
    assign is_k = k28;
    assign code_err = ~lo[5] | ~hi[3];

endmodule

// File: tb/serial_frame_bist_loop_control_assertions.sv
// Port-level checks for the framing, self-test and loop-through block
`timescale 1ns/1ps
module serial_frame_bist_loop_control_checker
    import serial_link_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic rx_selftest_enable_n,
    input wire logic cascade_timing_strap,
    input wire logic rx_fifo_nearly_full,
    input wire logic [7:0] tx_fifo_char,
    input wire logic tx_char_req,
    input wire logic [7:0] tx_enc_char,
    input wire logic tx_enc_from_loop,
    input wire logic tx_fifo_pop,
    input wire logic [7:0] rx_char,
    input wire logic rx_char_valid,
    input wire logic rx_violation,
    input wire logic rx_fifo_full_flag
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Mode must hold across the request so the synchroniser cannot switch mid-transfer
    sequence fifo_req;
        tx_char_req && !tx_enc_from_loop ##1 !tx_enc_from_loop;
    endsequence
    sequence loop_req;
        tx_char_req && tx_enc_from_loop ##1 tx_enc_from_loop;
    endsequence
    sequence selftest_steady;
        (!rx_selftest_enable_n && cascade_timing_strap)[*4];
    endsequence

    a_fifo_source: assert property (fifo_req |-> tx_enc_char == $past(tx_fifo_char) && tx_fifo_pop)
        else $error("encoder char not taken from transmit fifo");
    a_loop_source: assert property (loop_req |-> tx_enc_char == $past(rx_char) && !tx_fifo_pop)
        else $error("encoder char not taken from received char");
    a_pop_cause: assert property (tx_fifo_pop |-> $past(tx_char_req))
        else $error("fifo pop without a request");
    a_viol_idle: assert property (rx_selftest_enable_n [*5] |-> !rx_violation)
        else $error("violation raised outside self-test");
    a_viol_per_char: assert property ($changed(rx_violation) && !rx_selftest_enable_n |-> rx_char_valid)
        else $error("violation changed between characters");
    a_pass_pulse: assert property (selftest_steady ##0 rx_fifo_full_flag |-> rx_char_valid ##1 !rx_fifo_full_flag)
        else $error("pass pulse not a single cycle on a character");
    a_full_polarity: assert property ((rx_selftest_enable_n && $stable(cascade_timing_strap)
        && $stable(rx_fifo_nearly_full)) [*5] |-> rx_fifo_full_flag == (cascade_timing_strap ~^ rx_fifo_nearly_full))
        else $error("full flag polarity wrong");
    a_char_spacing: assert property (rx_char_valid |=> !rx_char_valid [*5])
        else $error("characters closer than the bit rate allows");
    a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("bus response not ready and okay");
endmodule

bind serial_frame_bist_loop_control serial_frame_bist_loop_control_checker i_chk (
    .hclk, .hresetn, .hreadyout, .hresp, .rx_selftest_enable_n, .cascade_timing_strap,
    .rx_fifo_nearly_full, .tx_fifo_char, .tx_char_req, .tx_enc_char, .tx_enc_from_loop,
    .tx_fifo_pop, .rx_char, .rx_char_valid, .rx_violation, .rx_fifo_full_flag
);

// File: tb/link_tx_model.sv
// Remote transmitter: serialises 10-bit characters onto the link, first bit a
`timescale 1ns/1ps
module link_tx_model #(
    parameter int HALF_NS = 80
) (
    output logic link_clk,
    output logic link_data
);
    initial begin
        link_clk = 1'h0;
        link_data = 1'h0;
    end

    // Clock stands low between frames; data then flips so a stale bit never looks valid
    task automatic send(input logic [9:0] code, input int n);
        #3;
        for (int i = 9; i > 9 - n; i--) begin
            link_data = code[i];
            #(HALF_NS);
            link_clk = 1'h1;
            #(HALF_NS);
            link_clk = 1'h0;
        end
        link_data = ~link_data;
    endtask
endmodule

// File: tb/test_serial_frame_bist_loop_control.sv
// Self-checking bench for the framing, self-test and loop-through block
`timescale 1ns/1ps
module test_serial_frame_bist_loop_control;
    import serial_link_pkg::*;
    typedef struct {
        logic loop;
        logic casc;
        logic nf;
        logic [7:0] fifo;
        logic [7:0] enc;
        logic pop;
        logic full;
    } row_s;
    // Loop rows expect the last received data char
    row_s rows [4] = '{
        '{1'h0, 1'h0, 1'h0, 8'h3C, 8'h3C, 1'h1, 1'h1},
        '{1'h0, 1'h1, 1'h1, 8'hC3, 8'hC3, 1'h1, 1'h1},
        '{1'h1, 1'h1, 1'h0, 8'h5A, 8'hB5, 1'h0, 1'h0},
        '{1'h1, 1'h0, 1'h1, 8'hA5, 8'hB5, 1'h0, 1'h0}
    };
    logic hclk, hresetn, hsel, hwrite, tx_char_req, realign_permit, rx_selftest_enable_n;
    logic loop_through_select, rate_range_strap, cascade_timing_strap, rx_fifo_nearly_full;
    logic [7:0] haddr, tx_fifo_char, tx_enc_char, rx_char;
    logic [1:0] htrans;
    logic [31:0] hwdata, hrdata, rd;
    logic hreadyout, hresp, link_clk, link_data, tx_enc_from_loop, tx_fifo_pop;
    logic rx_char_valid, rx_violation, rx_fifo_full_flag, irq, st_on;
    logic [8:0] lfsr = LFSR_SEED;
    int num_errors = 0;
    int n_checks = 0;
    int n_st = 0;
    int n_bad = 0;

    serial_frame_bist_loop_control i_serial_frame_bist_loop_control (
        .hclk, .hresetn, .clk_en(1'h1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .link_clk, .link_data,
        .realign_permit, .rx_selftest_enable_n, .loop_through_select, .rate_range_strap,
        .cascade_timing_strap, .rx_fifo_nearly_full, .tx_fifo_char, .tx_char_req,
        .tx_enc_char, .tx_enc_from_loop, .tx_fifo_pop, .rx_char, .rx_char_valid,
        .rx_violation, .rx_fifo_full_flag, .irq
    );
    link_tx_model i_link_tx_model (.link_clk, .link_data);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask

    task automatic frame(input logic [9:0] comma);
        i_link_tx_model.send(10'h280, 3);
        i_link_tx_model.send(comma, 10);
        i_link_tx_model.send(10'h2AA, 10);
        repeat (12) @(posedge hclk);
    endtask

    // Every data char sent in self-test is 8'hB5
    always @(posedge hclk) begin
        if (rx_char_valid === 1'h1 && st_on) begin
            check(rx_char, 8'hB5);
            check(rx_violation, lfsr[7:0] !== 8'hB5);
            check(rx_fifo_full_flag, n_st == SEQ_LEN - 1);
            n_bad <= n_bad + (lfsr[7:0] !== 8'hB5);
            lfsr <= {lfsr[7:0], lfsr[LFSR_TAP_A] ^ lfsr[LFSR_TAP_B]};
            n_st <= (n_st == SEQ_LEN - 1) ? 0 : n_st + 1;
        end else if (rx_char_valid === 1'h1) begin
            check(rx_violation, 1'h0);
        end
    end

    initial begin
        hclk = 1'h0;
        forever #5 hclk = ~hclk;
    end

    initial begin
        #(950_000);
        num_errors++;
        results();
    end

    initial begin
        {hresetn, hsel, hwrite, tx_char_req, loop_through_select, st_on} = '0;
        {cascade_timing_strap, rx_fifo_nearly_full, haddr, htrans, hwdata, tx_fifo_char} = '0;
        realign_permit = 1'h1;
        rx_selftest_enable_n = 1'h1;
        rate_range_strap = 1'h1;
        repeat (5) @(posedge hclk);
        hresetn <= 1'h1;
        ahb(1'h0, CTRL_OFS, 0);
        check(rd, CTRL_RESET);
        ahb(1'h0, 8'h1C, 0);
        check(rd, 0);
        ahb(1'h0, STATUS_OFS, 0);
        check(rd[STAT_RATE_BIT], 1'h1);
        frame(COMMA_NEG);
        check(rx_char, 8'hB5);
        check(irq, 1'h0);
        ahb(1'h0, INT_STAT_OFS, 0);
        check(rd[INT_REALIGN_BIT], 1'h1);
        ahb(1'h1, INT_EN_OFS, 32'h1 << INT_REALIGN_BIT);
        repeat (2) @(posedge hclk);
        check(irq, 1'h1);
        ahb(1'h1, INT_CLR_OFS, 32'h1 << INT_REALIGN_BIT);
        repeat (2) @(posedge hclk);
        check(irq, 1'h0);
        // Comma three bits off: a fixed boundary splits it, giving the shifted data char
        realign_permit <= 1'h0;
        frame(COMMA_NEG);
        check(rx_char, 8'h4A);
        ahb(1'h0, INT_STAT_OFS, 0);
        check(rd[INT_REALIGN_BIT], 1'h0);
        realign_permit <= 1'h1;
        frame(COMMA_POS);
        check(rx_char, 8'hB5);
        realign_permit <= 1'h0;
        foreach (rows[i]) begin
            loop_through_select <= rows[i].loop;
            cascade_timing_strap <= rows[i].casc;
            rx_fifo_nearly_full <= rows[i].nf;
            tx_fifo_char <= rows[i].fifo;
            repeat (6) @(posedge hclk);
            tx_char_req <= 1'h1;
            @(posedge hclk);
            tx_char_req <= 1'h0;
            @(posedge hclk);
            check(tx_enc_char, rows[i].enc);
            check(tx_fifo_pop, rows[i].pop);
            check(tx_enc_from_loop, rows[i].loop);
            check(rx_fifo_full_flag, rows[i].full);
        end
        loop_through_select <= 1'h0;
        cascade_timing_strap <= 1'h1;
        rx_fifo_nearly_full <= 1'h0;
        rx_selftest_enable_n <= 1'h0;
        st_on <= 1'h1;
        // Enable pin needs its two synchroniser stages before status shows it
        repeat (3) @(posedge hclk);
        ahb(1'h0, STATUS_OFS, 0);
        check(rd[STAT_SELFTEST_BIT], 1'h1);
        // One char past a full pass shows the sequence restarting from the seed
        for (int i = 0; i <= SEQ_LEN; i++) begin
            i_link_tx_model.send(10'h2AA, 10);
        end
        repeat (12) @(posedge hclk);
        check(n_st, 1);
        ahb(1'h0, COUNT_OFS, 0);
        check(rd[31:COUNT_LOOP_LSB], 16'h1);
        check(rd[COUNT_W-1:0], n_bad[15:0]);
        ahb(1'h0, INT_STAT_OFS, 0);
        check(rd[INT_LOOP_BIT], 1'h1);
        check(rd[INT_VIOL_BIT], 1'h1);
        check(rd[INT_CODE_ERR_BIT], 1'h0);
        ahb(1'h0, CHAR_OFS, 0);
        check(rd, (32'h2AA << CHAR_RAW_LSB) | 32'hB5);
        results();
    end
endmodule
